// File: rtl/jtl_defs.svh
// Offsets, field positions and reset values of the joint translation buffer
`ifndef JTL_DEFS_SVH
`define JTL_DEFS_SVH
`define JTL_ENTRIES      16
`define JTL_IDX_W        4
`define JTL_ADDR_W       8
`define JTL_OFF_MASK     8'h00
`define JTL_OFF_HI       8'h04
`define JTL_OFF_EVEN     8'h08
`define JTL_OFF_ODD      8'h0C
`define JTL_OFF_INDEX    8'h10
`define JTL_OFF_CMD      8'h14
`define JTL_OFF_ADDRESS_SPACE_IDENTIFIER     8'h18
`define JTL_OFF_STATUS   8'h1C
`define JTL_KEEP_MASK    32'h01FF_E000
`define JTL_KEEP_HI      32'hFFFF_E0FF
`define JTL_KEEP_STAGE   32'h03FF_FFFF
`define JTL_KEEP_INDEX   32'h0000_000F
`define JTL_KEEP_ADDRESS_SPACE_IDENTIFIER    32'h0000_00FF
`define JTL_ZERO32       32'h0000_0000
`define JTL_PM_LSB       13
`define JTL_PM_MSB       24
`define JTL_VPN_LSB      13
`define JTL_FIXED_LSB    25
`define JTL_SEL_BASE     12
`define JTL_ADDRESS_SPACE_IDENTIFIER_MSB     7
`define JTL_PFN_LSB      6
`define JTL_PFN_MSB      25
`define JTL_ATTR_LSB     3
`define JTL_ATTR_MSB     5
`define JTL_D_BIT        2
`define JTL_V_BIT        1
`define JTL_G_BIT        0
`define JTL_CMD_WR_BIT   0
`define JTL_CMD_RD_BIT   1
`define JTL_MASK_PAIRS   6
`define JTL_MASK_BITS    12
`define JTL_RESP_OKAY    2'h0
`define JTL_RESP_SLVERR  2'h2
`endif

// File: rtl/jtl_pkg.sv
// Types and helper functions of the joint translation buffer
package jtl_pkg;
`include "jtl_defs.svh"

	typedef struct packed
	{
		logic [18:0] virtual_page_pair_number;
		logic [7:0]  address_space_identifier;
		logic        global;
		logic [5:0]  page_size_mask;
	} jtl_tag_type;

	typedef struct packed
	{
		logic [19:0] frame_number;
		logic [2:0]  attr;
		logic        write_enable;
		logic        valid;
	} jtl_page_type;

	typedef enum logic {JTL_SRC_INST, JTL_SRC_DATA} jtl_src_type;

	// Compressed mask back to the 12-bit software form
	function automatic logic [11:0] jtl_expand_mask(input logic [5:0] c);
		logic [11:0] e;
		e = 12'h000;
		for (int i = 0; i < `JTL_MASK_PAIRS; i++)
		begin
			e[2*i]   = c[i];
			e[2*i+1] = c[i];
		end
		return e;
	endfunction : jtl_expand_mask

	// One bit per pair; a pair with unequal bits collapses to unmasked
	function automatic logic [5:0] jtl_compress_mask(input logic [11:0] m);
		logic [5:0] c;
		c = 6'h00;
		for (int i = 0; i < `JTL_MASK_PAIRS; i++)
			c[i] = m[2*i] & m[2*i+1];
		return c;
	endfunction : jtl_compress_mask

	// Highest virtual bit left out of the compare picks the odd page
	function automatic logic jtl_select_bit(input logic [31:0] va, input logic [5:0] c);
		logic s;
		s = va[`JTL_SEL_BASE];
		for (int i = 0; i < `JTL_MASK_PAIRS; i++)
			if (c[i])
				s = va[`JTL_SEL_BASE + 2 + 2*i];
		return s;
	endfunction : jtl_select_bit

	// Frame bits above the page offset, virtual bits below it
	function automatic logic [31:0] jtl_physical(input logic [31:0] va, input logic [19:0] pfn,
		input logic [5:0] c);
		logic [31:0] pa;
		logic [11:0] e;
		e = jtl_expand_mask(c);
		pa = {pfn, va[`JTL_SEL_BASE-1:0]};
		for (int b = 0; b < `JTL_MASK_BITS; b++)
			if (e[b])
				pa[`JTL_SEL_BASE + b] = va[`JTL_SEL_BASE + b];
		return pa;
	endfunction : jtl_physical

	// Byte-lane merge of a bus write, reserved bits forced to zero
	function automatic logic [31:0] jtl_merge(input logic [31:0] old, input logic [31:0] wd,
		input logic [3:0] strb, input logic [31:0] keep);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++)
			if (strb[i])
				r[8*i +: 8] = wd[8*i +: 8];
		return r & keep;
	endfunction : jtl_merge
endpackage : jtl_pkg

// File: rtl/jtl_query_if.sv
// Lookup query shared by the per-entry comparators
`timescale 1ns/1ps
interface jtl_query_if;
	logic [31:0] virtual_address;
	logic [7:0]  address_space_identifier;
	modport issuer  (output virtual_address, output address_space_identifier);
	modport matcher (input virtual_address, input address_space_identifier);
endinterface : jtl_query_if

// File: rtl/jtl_entry_match.sv
// Tag comparator for one entry pair
`timescale 1ns/1ps
`include "jtl_defs.svh"
module jtl_entry_match
(
	jtl_query_if.matcher      query,      // Address and identifier under lookup
	input wire jtl_pkg::jtl_tag_type tag, // Stored tag of this pair
	output logic              match,      // Tag hit
	output logic              odd_select  // High picks the odd page
);
	logic [11:0] cmp_mask;
	logic        vpn_ok;
	logic        address_space_identifier_ok;

	// Mask is derived per entry on every lookup since page size differs per pair
	always_comb
	begin
		cmp_mask = jtl_pkg::jtl_expand_mask(tag.page_size_mask); // [R7] [R8] [R11]
		vpn_ok = (query.virtual_address[31:`JTL_FIXED_LSB]
			== tag.virtual_page_pair_number[18:`JTL_FIXED_LSB-`JTL_VPN_LSB]) // [R12]
			&& (((query.virtual_address[`JTL_PM_MSB:`JTL_VPN_LSB]
			^ tag.virtual_page_pair_number[`JTL_PM_MSB-`JTL_VPN_LSB:0]) & ~cmp_mask) == 12'h000); // [R12] [R8]
		address_space_identifier_ok = tag.global
			|| (query.address_space_identifier == tag.address_space_identifier); // [R13] [R14]
		match = vpn_ok & address_space_identifier_ok; // [R3]
		odd_select = jtl_pkg::jtl_select_bit(query.virtual_address, tag.page_size_mask); // [R6] [R9]
	end
endmodule : jtl_entry_match

// File: rtl/jtl_top.sv
// Joint translation buffer with AXI4-Lite staging registers and two lookup ports
//
// Chosen here: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/1ps
`include "jtl_defs.svh"
// How it works
// R1: Sixteen fully associative tag entries, each mapping an even and odd page.
// R2: Page sizes 4 KB to 16 MB per pair, into a 4 GB physical space.
// R3: Every lookup compares upper address and identifier against all tags at once.
// R4: Instruction and data requests share the one translation structure.
// R5: Each tag owns an even and an odd physical page entry.
// R6: Highest uncompared virtual bit picks the even or odd page.
// R7: Compared bits and select bit are derived per entry during each lookup.
// R8: Twelve-bit mask over bits 24 to 13 removes masked bits from compare.
// R9: Select bit is 12, then 14 up to 24 as pages grow.
// R10: Only seven mask codes are legal; pairs of mask bits must match.
// R11: Mask stored as six bits, always shown to software as twelve.
// R12: Bits 31 to 25 always compared; 24 to 13 when unmasked.
// R13: Global entries ignore the address space identifier.
// R14: Non-global entries need an equal eight-bit address space identifier.
// R15: Stored global flag is the AND of both staged global bits.
// R16: Selected page not valid gives an invalid exception, no translation.
// R17: Store to a page without write enable gives a modified exception.
// R18: Requester retries a micro buffer miss next cycle and tolerates busy stalls.
// R19: No matching entry reports a miss instead of an address.
// R20: Hit address joins frame bits above the page offset with virtual bits.
module jtl_top
(
	input  wire logic        aclk,                 // Core clock
	input  wire logic        aresetn,              // Synchronous reset, low active
	input  wire logic [7:0]  s_axi_awaddr,         // Write address
	input  wire logic [2:0]  s_axi_awprot,         // Unused protection
	input  wire logic        s_axi_awvalid,        // Write address valid
	output logic             s_axi_awready,        // Write address ready
	input  wire logic [31:0] s_axi_wdata,          // Write data
	input  wire logic [3:0]  s_axi_wstrb,          // Byte enables
	input  wire logic        s_axi_wvalid,         // Write data valid
	output logic             s_axi_wready,         // Write data ready
	output logic [1:0]       s_axi_bresp,          // Write response
	output logic             s_axi_bvalid,         // Write response valid
	input  wire logic        s_axi_bready,         // Write response ready
	input  wire logic [7:0]  s_axi_araddr,         // Read address
	input  wire logic [2:0]  s_axi_arprot,         // Unused protection
	input  wire logic        s_axi_arvalid,        // Read address valid
	output logic             s_axi_arready,        // Read address ready
	output logic [31:0]      s_axi_rdata,          // Read data
	output logic [1:0]       s_axi_rresp,          // Read response
	output logic             s_axi_rvalid,         // Read valid
	input  wire logic        s_axi_rready,         // Read ready
	input  wire logic        inst_req_valid,       // Fetch translation request
	output logic             inst_req_ready,       // Fetch request taken
	input  wire logic [31:0] inst_req_address,     // Fetch virtual address
	input  wire logic        data_req_valid,       // Data translation request
	output logic             data_req_ready,       // Data request taken
	input  wire logic [31:0] data_req_address,     // Data virtual address
	input  wire logic        data_req_store,       // Data access is a store
	output logic             rsp_valid,            // Result pulse
	output logic             rsp_fetch,            // Result belongs to a fetch
	output logic             rsp_hit,              // Translation succeeded
	output logic             rsp_miss,             // No entry matched
	output logic             rsp_invalid,          // Page not valid
	output logic             rsp_modified,         // Store to write-protected page
	output logic [31:0]      rsp_physical_address, // Translated address
	output logic [2:0]       rsp_attr              // Cache attribute of the page
);
	jtl_pkg::jtl_tag_type  tag_q [`JTL_ENTRIES];
	jtl_pkg::jtl_page_type even_q [`JTL_ENTRIES];
	jtl_pkg::jtl_page_type odd_q [`JTL_ENTRIES];
	logic [31:0]           mask_stage_q;
	logic [31:0]           hi_stage_q;
	logic [31:0]           even_stage_q;
	logic [31:0]           odd_stage_q;
	logic [31:0]           index_q;
	logic [31:0]           address_space_identifier_q;
	logic                  wr_pend_q;
	logic                  rd_pend_q;
	logic                  busy;
	logic                  aw_have_q;
	logic                  w_have_q;
	logic [7:0]            awaddr_q;
	logic [31:0]           wdata_q;
	logic [3:0]            wstrb_q;
	logic                  do_write;
	logic                  wr_mapped;
	logic                  bvalid_q;
	logic [1:0]            bresp_q;
	logic                  rvalid_q;
	logic [1:0]            rresp_q;
	logic [31:0]           rdata_q;
	logic [31:0]           rd_mux;
	logic                  rd_mapped;
	logic [`JTL_ENTRIES-1:0] hit_vec;
	logic [`JTL_ENTRIES-1:0] odd_vec;
	logic [`JTL_IDX_W-1:0] hit_idx;
	logic                  any_hit;
	jtl_pkg::jtl_page_type page;
	jtl_pkg::jtl_src_type  src;
	logic                  take;
	logic                  is_store;
	logic [3:0]            last_q;
	logic [`JTL_IDX_W-1:0] sel_idx;
	jtl_pkg::jtl_tag_type  sel_tag;
	jtl_query_if           query ();

	// A pending entry write or read-back holds off lookups for one cycle
	assign busy = wr_pend_q | rd_pend_q;
	assign sel_idx = index_q[`JTL_IDX_W-1:0];
	assign sel_tag = tag_q[sel_idx];

	// Data side wins arbitration; fetch waits, which its requester tolerates
	assign data_req_ready = ~busy;                                   // [R18]
	assign inst_req_ready = ~busy & ~data_req_valid;                 // [R4] [R18]
	assign take = ~busy & (data_req_valid | inst_req_valid);
	assign src = data_req_valid ? jtl_pkg::JTL_SRC_DATA : jtl_pkg::JTL_SRC_INST;
	assign is_store = data_req_valid & data_req_store;
	assign query.virtual_address = data_req_valid ? data_req_address : inst_req_address; // [R4]
	assign query.address_space_identifier = address_space_identifier_q[`JTL_ADDRESS_SPACE_IDENTIFIER_MSB:0];

	// One comparator per pair, all in parallel
	for (genvar g = 0; g < `JTL_ENTRIES; g++)
	begin : gen_match
		jtl_entry_match u_match
		(
			.query      (query),
			.tag        (tag_q[g]),
			.match      (hit_vec[g]),
			.odd_select (odd_vec[g])
		); // [R1] [R3]
	end

	// Lowest index wins should software leave overlapping tags behind
	always_comb
	begin
		hit_idx = {`JTL_IDX_W{1'b0}};
		any_hit = 1'b0;
		for (int i = `JTL_ENTRIES - 1; i >= 0; i--)
			if (hit_vec[i])
			begin
				hit_idx = i[`JTL_IDX_W-1:0];
				any_hit = 1'b1;
			end
		page = odd_vec[hit_idx] ? odd_q[hit_idx] : even_q[hit_idx]; // [R5] [R6]
	end

	// Lookup result, registered one cycle after the request is taken
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			rsp_valid <= 1'b0;
			rsp_fetch <= 1'b0;
			rsp_hit <= 1'b0;
			rsp_miss <= 1'b0;
			rsp_invalid <= 1'b0;
			rsp_modified <= 1'b0;
			rsp_physical_address <= `JTL_ZERO32;
			rsp_attr <= 3'h0;
		end
		else
		begin
			rsp_valid <= take;
			if (take)
			begin
				rsp_fetch <= (src == jtl_pkg::JTL_SRC_INST);
				rsp_miss <= ~any_hit;                                       // [R19]
				rsp_invalid <= any_hit & ~page.valid;                       // [R16]
				rsp_modified <= any_hit & page.valid & is_store & ~page.write_enable; // [R17]
				rsp_hit <= any_hit & page.valid & ~(is_store & ~page.write_enable);
				rsp_attr <= page.attr;
				// Address only given out on a full hit
				if (any_hit & page.valid & ~(is_store & ~page.write_enable))
					rsp_physical_address <= jtl_pkg::jtl_physical(query.virtual_address,
						page.frame_number, tag_q[hit_idx].page_size_mask); // [R20] [R2]
				else
					rsp_physical_address <= `JTL_ZERO32;                    // [R19]
			end
		end
	end

	// Status of the most recent lookup for software
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			last_q <= 4'h0;
		else if (take)
			last_q <= {is_store & ~page.write_enable & any_hit & page.valid,
				any_hit & ~page.valid, ~any_hit, src == jtl_pkg::JTL_SRC_INST};
	end

	// Entry array: written from the staging registers at the selected index
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			for (int i = 0; i < `JTL_ENTRIES; i++)
			begin
				tag_q[i] <= '0;
				even_q[i] <= '0;
				odd_q[i] <= '0;
			end
		end
		else if (wr_pend_q)
		begin
			tag_q[sel_idx].virtual_page_pair_number <= hi_stage_q[31:`JTL_VPN_LSB];
			tag_q[sel_idx].address_space_identifier <= hi_stage_q[`JTL_ADDRESS_SPACE_IDENTIFIER_MSB:0]; // [R14]
			tag_q[sel_idx].global <= even_stage_q[`JTL_G_BIT] & odd_stage_q[`JTL_G_BIT]; // [R15]
			tag_q[sel_idx].page_size_mask <=
				jtl_pkg::jtl_compress_mask(mask_stage_q[`JTL_PM_MSB:`JTL_PM_LSB]); // [R11] [R10]
			even_q[sel_idx] <= {even_stage_q[`JTL_PFN_MSB:`JTL_PFN_LSB],
				even_stage_q[`JTL_ATTR_MSB:`JTL_ATTR_LSB], even_stage_q[`JTL_D_BIT],
				even_stage_q[`JTL_V_BIT]}; // [R5]
			odd_q[sel_idx] <= {odd_stage_q[`JTL_PFN_MSB:`JTL_PFN_LSB],
				odd_stage_q[`JTL_ATTR_MSB:`JTL_ATTR_LSB], odd_stage_q[`JTL_D_BIT],
				odd_stage_q[`JTL_V_BIT]}; // [R5]
		end
	end

	// Bus write channels are held independently so either may come first
	assign s_axi_awready = ~aw_have_q & ~bvalid_q;
	assign s_axi_wready = ~w_have_q & ~bvalid_q;
	assign do_write = aw_have_q & w_have_q & ~bvalid_q & ~busy;
	assign wr_mapped = (awaddr_q <= `JTL_OFF_ADDRESS_SPACE_IDENTIFIER) && (awaddr_q[1:0] == 2'h0);

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_have_q <= 1'b0;
			w_have_q <= 1'b0;
			awaddr_q <= 8'h00;
			wdata_q <= `JTL_ZERO32;
			wstrb_q <= 4'h0;
		end
		else
		begin
			if (s_axi_awvalid & s_axi_awready)
			begin
				aw_have_q <= 1'b1;
				awaddr_q <= s_axi_awaddr;
			end
			else if (do_write)
				aw_have_q <= 1'b0;
			if (s_axi_wvalid & s_axi_wready)
			begin
				w_have_q <= 1'b1;
				wdata_q <= s_axi_wdata;
				wstrb_q <= s_axi_wstrb;
			end
			else if (do_write)
				w_have_q <= 1'b0;
		end
	end

	// Write response; status register and holes answer with an error
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			bvalid_q <= 1'b0;
			bresp_q <= `JTL_RESP_OKAY;
		end
		else if (do_write)
		begin
			bvalid_q <= 1'b1;
			bresp_q <= wr_mapped ? `JTL_RESP_OKAY : `JTL_RESP_SLVERR;
		end
		else if (s_axi_bready)
			bvalid_q <= 1'b0;
	end

	assign s_axi_bvalid = bvalid_q;
	assign s_axi_bresp = bresp_q;

	// Command pulses; a command word with no byte 0 enable does nothing
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			wr_pend_q <= 1'b0;
			rd_pend_q <= 1'b0;
		end
		else
		begin
			wr_pend_q <= do_write & (awaddr_q == `JTL_OFF_CMD) & wstrb_q[0] & wdata_q[`JTL_CMD_WR_BIT];
			rd_pend_q <= do_write & (awaddr_q == `JTL_OFF_CMD) & wstrb_q[0]
				& wdata_q[`JTL_CMD_RD_BIT] & ~wdata_q[`JTL_CMD_WR_BIT];
		end
	end

	// Staging registers: software writes, or a read-back of the selected entry
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			mask_stage_q <= `JTL_ZERO32;
			hi_stage_q <= `JTL_ZERO32;
			even_stage_q <= `JTL_ZERO32;
			odd_stage_q <= `JTL_ZERO32;
			index_q <= `JTL_ZERO32;
			address_space_identifier_q <= `JTL_ZERO32;
		end
		else if (rd_pend_q)
		begin
			mask_stage_q <= `JTL_ZERO32;
			mask_stage_q[`JTL_PM_MSB:`JTL_PM_LSB] <= jtl_pkg::jtl_expand_mask(sel_tag.page_size_mask); // [R11]
			hi_stage_q <= {sel_tag.virtual_page_pair_number, 5'h00, sel_tag.address_space_identifier};
			even_stage_q <= {6'h00, even_q[sel_idx], sel_tag.global};
			odd_stage_q <= {6'h00, odd_q[sel_idx], sel_tag.global};
		end
		else if (do_write)
		begin
			case (awaddr_q)
				`JTL_OFF_MASK:  mask_stage_q <= jtl_pkg::jtl_merge(mask_stage_q, wdata_q, wstrb_q, `JTL_KEEP_MASK);
				`JTL_OFF_HI:    hi_stage_q <= jtl_pkg::jtl_merge(hi_stage_q, wdata_q, wstrb_q, `JTL_KEEP_HI);
				`JTL_OFF_EVEN:  even_stage_q <= jtl_pkg::jtl_merge(even_stage_q, wdata_q, wstrb_q, `JTL_KEEP_STAGE);
				`JTL_OFF_ODD:   odd_stage_q <= jtl_pkg::jtl_merge(odd_stage_q, wdata_q, wstrb_q, `JTL_KEEP_STAGE);
				`JTL_OFF_INDEX: index_q <= jtl_pkg::jtl_merge(index_q, wdata_q, wstrb_q, `JTL_KEEP_INDEX);
				`JTL_OFF_ADDRESS_SPACE_IDENTIFIER:  address_space_identifier_q <= jtl_pkg::jtl_merge(address_space_identifier_q, wdata_q, wstrb_q, `JTL_KEEP_ADDRESS_SPACE_IDENTIFIER);
				default:        address_space_identifier_q <= address_space_identifier_q;
			endcase
		end
	end

	// Read decode
	always_comb
	begin
		rd_mapped = 1'b1;
		case (s_axi_araddr)
			`JTL_OFF_MASK:   rd_mux = mask_stage_q;
			`JTL_OFF_HI:     rd_mux = hi_stage_q;
			`JTL_OFF_EVEN:   rd_mux = even_stage_q;
			`JTL_OFF_ODD:    rd_mux = odd_stage_q;
			`JTL_OFF_INDEX:  rd_mux = index_q;
			`JTL_OFF_CMD:    rd_mux = {30'h0000_0000, rd_pend_q, wr_pend_q};
			`JTL_OFF_ADDRESS_SPACE_IDENTIFIER:   rd_mux = address_space_identifier_q;
			`JTL_OFF_STATUS: rd_mux = {27'h000_0000, last_q, busy};
			default:
			begin
				rd_mux = `JTL_ZERO32;
				rd_mapped = 1'b0;
			end
		endcase
	end

	// Read channel: data registered on the address handshake
	assign s_axi_arready = ~rvalid_q;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			rvalid_q <= 1'b0;
			rresp_q <= `JTL_RESP_OKAY;
			rdata_q <= `JTL_ZERO32;
		end
		else if (s_axi_arvalid & s_axi_arready)
		begin
			rvalid_q <= 1'b1;
			rdata_q <= rd_mux;
			rresp_q <= rd_mapped ? `JTL_RESP_OKAY : `JTL_RESP_SLVERR;
		end
		else if (s_axi_rready)
			rvalid_q <= 1'b0;
	end

	assign s_axi_rvalid = rvalid_q;
	assign s_axi_rdata = rdata_q;
	assign s_axi_rresp = rresp_q;
endmodule : jtl_top

// File: bench/jtl_top_properties.sv
// Concurrent checks on the lookup ports and register bus answers
`timescale 1ns/1ps
module jtl_top_properties
(
	input wire logic        aclk, // Core clock
	input wire logic        aresetn, // Synchronous reset, low active
	input wire logic        s_axi_bvalid, // Write response valid
	input wire logic        s_axi_bready, // Write response ready
	input wire logic        s_axi_rvalid, // Read valid
	input wire logic        s_axi_rready, // Read ready
	input wire logic [31:0] s_axi_rdata, // Read data
	input wire logic        inst_req_valid, // Fetch request
	input wire logic        inst_req_ready, // Fetch taken
	input wire logic [31:0] inst_req_address, // Fetch address
	input wire logic        data_req_valid, // Data request
	input wire logic        data_req_ready, // Data taken
	input wire logic [31:0] data_req_address, // Data address
	input wire logic        data_req_store, // Store access
	input wire logic        rsp_valid, // Result pulse
	input wire logic        rsp_fetch, // Result of a fetch
	input wire logic        rsp_hit, // Hit
	input wire logic        rsp_miss, // Miss
	input wire logic        rsp_invalid, // Invalid page
	input wire logic        rsp_modified, // Protected store
	input wire logic [31:0] rsp_physical_address // Translated address
);
	logic [31:0] va_q; // Address of the latest taken request
	logic        dt;   // Data request taken
	logic        it;   // Fetch request taken
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	assign dt = data_req_valid && data_req_ready;
	assign it = inst_req_valid && inst_req_ready;
	// Remember the address so the page offset of a hit can be judged
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			va_q <= 32'h0;
		else if (dt)
			va_q <= data_req_address;
		else if (it)
			va_q <= inst_req_address;
	end
	a_data_answer: assert property (dt |=> rsp_valid && !rsp_fetch) else $error("data result missing");
	a_inst_answer: assert property (it |=> rsp_valid && rsp_fetch) else $error("fetch result missing");
	a_data_first: assert property (data_req_valid |-> !inst_req_ready) else $error("fetch beat data");
	a_no_spurious: assert property (!dt && !it |=> !rsp_valid) else $error("result without request");
	a_one_outcome: assert property (rsp_valid |-> $onehot({rsp_hit, rsp_miss, rsp_invalid, rsp_modified}))
		else $error("outcome not unique");
	a_fail_no_addr: assert property (rsp_valid && !rsp_hit |-> rsp_physical_address == 32'h0)
		else $error("address on failure");
	a_page_offset: assert property (rsp_valid && rsp_hit |-> rsp_physical_address[11:0] == va_q[11:0])
		else $error("page offset wrong");
	a_load_no_mod: assert property ((dt && !data_req_store) || it |=> !rsp_modified)
		else $error("modified on a load");
	a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid) else $error("bvalid dropped");
	a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data unstable");
endmodule : jtl_top_properties

// File: bench/jtl_fetch_model.sv
// Fetch requester that retries a micro buffer miss through the joint buffer
`timescale 1ns/1ps
module jtl_fetch_model
(
	input  wire logic        aclk,      // Core clock
	input  wire logic        aresetn,   // Synchronous reset, low active
	input  wire logic        go,        // Start one fetch translation
	input  wire logic [31:0] go_addr,   // Address that missed
	input  wire logic        ready,     // Request taken
	output logic             req_valid, // Request to the buffer
	output logic [31:0]      req_addr,  // Address, scrambled while idle
	output logic             done       // High in the result cycle
);
	// Present the missed address and hold it through busy stalls
	always_ff @(posedge aclk)
	begin
		done <= req_valid && ready;
		if (!aresetn)
		begin
			req_valid <= 1'h0;
			req_addr  <= 32'h0;
		end
		else if (req_valid && ready)
		begin
			req_valid <= 1'h0;
			req_addr  <= ~req_addr; // Released lines must not echo the last address
		end
		else if (go && !req_valid)
		begin
			req_valid <= 1'h1;
			req_addr  <= go_addr;
		end
		else if (!req_valid)
			req_addr <= ~req_addr;
	end
endmodule : jtl_fetch_model

// File: bench/jtl_top_tb.sv
// Self-checking bench of the joint translation buffer
`timescale 1ns/1ps
module jtl_top_tb;
	logic        aclk = 1'h0, aresetn = 1'h0, go = 1'h0, done;
	logic [7:0]  s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
	logic [31:0] s_axi_wdata = 32'h0, go_addr = 32'h0, data_req_address = 32'h0;
	logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
	logic        s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, data_req_valid = 1'h0, data_req_store = 1'h0;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	logic [31:0] s_axi_rdata, inst_req_address, rsp_physical_address;
	logic        inst_req_valid, inst_req_ready, data_req_ready;
	logic        rsp_valid, rsp_fetch, rsp_hit, rsp_miss, rsp_invalid, rsp_modified;
	logic [2:0]  rsp_attr;
	int          err_total = 0, total_checks = 0;
	// Free-running core clock
	always #4 aclk = ~aclk;
	jtl_top dut (.*, .s_axi_awprot(3'h0), .s_axi_wstrb(4'hF), .s_axi_arprot(3'h0));
	jtl_fetch_model fm (.aclk, .aresetn, .go, .go_addr, .ready(inst_req_ready), .req_valid(inst_req_valid),
		.req_addr(inst_req_address), .done);
	// Verdict and end of run
	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : report_and_stop
	// Compare one value and count the outcome
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			err_total++;
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	// Register write; each channel is released when taken
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = 2'h0);
		logic ta, tw, tb;
		logic [1:0] r;
		tb = 1'h0;
		@(posedge aclk);
		s_axi_awaddr  <= a;
		s_axi_wdata   <= d;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid  <= 1'h1;
		s_axi_bready  <= 1'h1;
		while (!tb)
		begin
			@(negedge aclk);
			ta = s_axi_awvalid && s_axi_awready;
			tw = s_axi_wvalid && s_axi_wready;
			tb = s_axi_bvalid;
			r  = s_axi_bresp;
			@(posedge aclk);
			if (ta)
				s_axi_awvalid <= 1'h0;
			if (tw)
				s_axi_wvalid <= 1'h0;
		end
		s_axi_bready <= 1'h0;
		chk("bresp", {30'h0, r}, {30'h0, er});
	endtask : wr
	// Register read with expected data and response
	task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er = 2'h0);
		logic ta, tr;
		tr = 1'h0;
		@(posedge aclk);
		s_axi_araddr  <= a;
		s_axi_arvalid <= 1'h1;
		s_axi_rready  <= 1'h1;
		while (!tr)
		begin
			@(negedge aclk);
			ta = s_axi_arvalid && s_axi_arready;
			tr = s_axi_rvalid;
			if (tr)
			begin
				chk("rdata", s_axi_rdata, ed);
				chk("rresp", {30'h0, s_axi_rresp}, {30'h0, er});
			end
			@(posedge aclk);
			if (ta)
				s_axi_arvalid <= 1'h0;
		end
		s_axi_rready <= 1'h0;
	endtask : rd
	// Judge the result cycle: fetch, hit, miss, invalid, modified
	task automatic res(input logic [4:0] ef, input logic [31:0] ep);
		chk("rsp_valid", {31'h0, rsp_valid}, 32'h1);
		chk("flags", {27'h0, rsp_fetch, rsp_hit, rsp_miss, rsp_invalid, rsp_modified}, {27'h0, ef});
		chk("phys", rsp_physical_address, ep);
	endtask : res
	// Data lookup held until taken
	task automatic dl(input logic [31:0] va, input logic st, input logic [4:0] ef, input logic [31:0] ep);
		logic tk;
		tk = 1'h0;
		@(posedge aclk);
		data_req_valid   <= 1'h1;
		data_req_address <= va;
		data_req_store   <= st;
		while (!tk)
		begin
			@(negedge aclk);
			tk = data_req_ready;
			@(posedge aclk);
		end
		data_req_valid   <= 1'h0;
		data_req_address <= ~va; // Idle lines carry no stale address
		data_req_store   <= ~st;
		@(negedge aclk);
		res(ef, ep);
	endtask : dl
	// Fetch lookup through the requester model
	task automatic fl(input logic [31:0] va, input logic [4:0] ef, input logic [31:0] ep);
		@(posedge aclk);
		go      <= 1'h1;
		go_addr <= va;
		@(posedge aclk);
		go <= 1'h0;
		do
			@(negedge aclk);
		while (done !== 1'h1);
		res(ef, ep);
	endtask : fl
	// Stage one pair and commit it at the given index
	task automatic ent(input logic [3:0] ix, input logic [31:0] m, h, ev, od);
		wr(8'h00, m);
		wr(8'h04, h);
		wr(8'h08, ev);
		wr(8'h0C, od);
		wr(8'h10, {28'h0, ix});
		wr(8'h14, 32'h1);
	endtask : ent
	// Hang guard, far beyond the test length
	initial
	begin
		#80000;
		err_total++;
		report_and_stop();
	end
	initial
	begin
		repeat (20) @(posedge aclk);
		aresetn <= 1'h1;
		// Small pages, private identifier, global bits disagree
		wr(8'h18, 32'h5);
		ent(4'h0, 32'h0, 32'h2468_A005, 32'h0155_555F, 32'h002A_AA9A);
		dl(32'h2468_A123, 1'h0, 5'h08, 32'h5555_5123);
		chk("attr", {29'h0, rsp_attr}, 32'h3);
		dl(32'h2468_B004, 1'h1, 5'h01, 32'h0);
		fl(32'h2468_BFFC, 5'h18, 32'h0AAA_AFFC);
		wr(8'h18, 32'h6);
		dl(32'h2468_A123, 1'h0, 5'h04, 32'h0);
		$display("test small pages done");
		// Largest page, global, odd half not valid, fetch and data together
		ent(4'h1, 32'h01FF_E000, 32'h8000_0033, 32'h03FC_0007, 32'h0000_0001);
		dl(32'h80AB_CDEF, 1'h1, 5'h08, 32'hFFAB_CDEF);
		fork
			fl(32'h8100_0000, 5'h12, 32'h0);
			begin
				@(posedge aclk);
				dl(32'h8200_0000, 1'h0, 5'h04, 32'h0);
			end
		join
		$display("test large page done");
		// Read the pair back in the software form
		wr(8'h00, 32'h0);
		wr(8'h08, 32'h0);
		wr(8'h14, 32'h2);
		rd(8'h00, 32'h01FF_E000);
		rd(8'h08, 32'h03FC_0007);
		rd(8'h0C, 32'h0000_0001);
		rd(8'h20, 32'h0, 2'h2);
		wr(8'h1C, 32'h1, 2'h2);
		$display("test register access done");
		report_and_stop();
	end
endmodule : jtl_top_tb
bind jtl_top jtl_top_properties u_props (.*);
